// file: src/slcs_pkg.sv
// Purpose: Constants for the serial link control-symbol layer.
// Assumes: 8b/10b code groups, bit order abcdei fghj, a as MSB.
// Notes:   Special groups hold the negative-disparity form; positive is its inverse.
package slcs_pkg;
   // ------------------------------------------------------------
   // Ordered sets
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      SLCS_OS_IDLE, SLCS_OS_EOP, SLCS_OS_BYTE_DIS, SLCS_OS_FLOW_ON, SLCS_OS_FLOW_OFF,
      SLCS_OS_ERROR, SLCS_OS_INIT0, SLCS_OS_INIT1, SLCS_OS_LINK, SLCS_OS_NONE
   } slcs_os_e;
   // ------------------------------------------------------------
   // Special groups, octet and negative-disparity code
   // ------------------------------------------------------------
   localparam logic [7:0] K28_0_OCT = 8'h1C;
   localparam logic [7:0] K28_1_OCT = 8'h3C;
   localparam logic [7:0] K28_2_OCT = 8'h5C;
   localparam logic [7:0] K28_3_OCT = 8'h7C;
   localparam logic [7:0] K28_4_OCT = 8'h9C;
   localparam logic [7:0] K28_5_OCT = 8'hBC;
   localparam logic [7:0] K28_6_OCT = 8'hDC;
   localparam logic [7:0] K28_7_OCT = 8'hFC;
   localparam logic [7:0] K23_7_OCT = 8'hF7;
   localparam logic [7:0] K27_7_OCT = 8'hFB;
   localparam logic [7:0] K29_7_OCT = 8'hFD;
   localparam logic [7:0] K30_7_OCT = 8'hFE;
   localparam logic [9:0] K28_0_NEG = 10'h0F4;
   localparam logic [9:0] K28_1_NEG = 10'h0F9;
   localparam logic [9:0] K28_2_NEG = 10'h0F5;
   localparam logic [9:0] K28_3_NEG = 10'h0F3;
   localparam logic [9:0] K28_4_NEG = 10'h0F2;
   localparam logic [9:0] K28_5_NEG = 10'h0FA;
   localparam logic [9:0] K28_6_NEG = 10'h0F6;
   localparam logic [9:0] K28_7_NEG = 10'h0F8;
   localparam logic [9:0] K23_7_NEG = 10'h3A8;
   localparam logic [9:0] K27_7_NEG = 10'h368;
   localparam logic [9:0] K29_7_NEG = 10'h2E8;
   localparam logic [9:0] K30_7_NEG = 10'h1E8;
   localparam int         LINK_TIMER_CYCLES = 4096;
   localparam logic       RD_RESET = 1'b0;
endpackage

// file: src/slcs_link.sv
// Purpose: Control-symbol encoder and decoder for an 8b/10b serial link.
// Assumes: Data groups are coded elsewhere; rx_is_data_in flags a valid data group.
// Notes:   Disparity is tracked per group from its ones count.
`timescale 1ns/1ps
`default_nettype none
module slcs_link #(
   parameter int LINK_TIMER = slcs_pkg::LINK_TIMER_CYCLES
) (
   // Clock and reset
   input  wire logic       clk_sys_in,
   input  wire logic       rst_in,
   // Transmit requests
   input  wire logic       v2_mode_in,
   input  wire logic       tx_data_valid_in,
   input  wire logic [9:0] tx_data_code_in,
   input  wire logic       tx_eop_in,
   input  wire logic       tx_byte_dis_in,
   input  wire logic       rx_queue_full_in,
   input  wire logic       pkt_fault_in,
   input  wire logic       link_init_in,
   input  wire logic       init0_in,
   input  wire logic       init1_in,
   output logic            tx_data_ready_out,
   output logic [9:0]      tx_code_out,
   output logic            tx_rd_out,
   // Receive side
   input  wire logic       rx_valid_in,
   input  wire logic [9:0] rx_code_in,
   input  wire logic       rx_is_data_in,
   output logic            rx_ctrl_out,
   output logic [7:0]      rx_octet_out,
   output logic [3:0]      rx_set_out,
   output logic            rx_error_out,
   output logic            remote_stop_out
);
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [3:0] ones(input logic [9:0] c);
      logic [3:0] n;
      n = 4'h0;
      for (int i = 0; i < 10; i++) begin
         n = n + {3'h0, c[i]};
      end
      return n;
   endfunction
   function automatic logic [9:0] pick(input logic [9:0] neg, input logic rd);
      return rd ? ~neg : neg;
   endfunction
   // ------------------------------------------------------------
   // Transmit selection
   // ------------------------------------------------------------
   logic        rd_tx_reg;
   logic [9:0]  tx_code_reg;
   logic [12:0] timer_reg;
   logic        link_due_reg;
   logic        fc_on_reg;
   slcs_pkg::slcs_os_e os_sel;
   logic [9:0]  neg_sel;
   logic [9:0]  tx_next;
   logic [3:0]  tx_ones;
   wire         fc_change = rx_queue_full_in != fc_on_reg;
   wire         timer_hit = timer_reg == 13'(LINK_TIMER - 1);
   // Priority: error, link, init, flow control, packet symbols, data, idle.
   always_comb begin
      if (pkt_fault_in) begin
         os_sel = slcs_pkg::SLCS_OS_ERROR;
      end else if (link_init_in || link_due_reg) begin
         os_sel = slcs_pkg::SLCS_OS_LINK;
      end else if (init0_in) begin
         os_sel = slcs_pkg::SLCS_OS_INIT0;
      end else if (init1_in) begin
         os_sel = slcs_pkg::SLCS_OS_INIT1;
      end else if (fc_change && !v2_mode_in) begin
         // Version 2.0 links skip these codes and send the next lower request (packet symbol, data or idle).
         os_sel = rx_queue_full_in ? slcs_pkg::SLCS_OS_FLOW_ON
                                   : slcs_pkg::SLCS_OS_FLOW_OFF;
      end else if (tx_eop_in) begin
         os_sel = slcs_pkg::SLCS_OS_EOP;
      end else if (tx_byte_dis_in) begin
         os_sel = slcs_pkg::SLCS_OS_BYTE_DIS;
      end else if (tx_data_valid_in) begin
         os_sel = slcs_pkg::SLCS_OS_NONE;
      end else begin
         os_sel = slcs_pkg::SLCS_OS_IDLE;
      end
   end
   always_comb begin
      case (os_sel)
         slcs_pkg::SLCS_OS_IDLE:     neg_sel = slcs_pkg::K28_5_NEG;
         slcs_pkg::SLCS_OS_EOP:      neg_sel = slcs_pkg::K29_7_NEG;
         slcs_pkg::SLCS_OS_BYTE_DIS: neg_sel = slcs_pkg::K23_7_NEG;
         slcs_pkg::SLCS_OS_FLOW_ON:  neg_sel = slcs_pkg::K28_0_NEG;
         slcs_pkg::SLCS_OS_FLOW_OFF: neg_sel = slcs_pkg::K28_2_NEG;
         slcs_pkg::SLCS_OS_ERROR:    neg_sel = slcs_pkg::K28_1_NEG;
         slcs_pkg::SLCS_OS_INIT0:    neg_sel = slcs_pkg::K28_4_NEG;
         slcs_pkg::SLCS_OS_INIT1:    neg_sel = slcs_pkg::K28_6_NEG;
         slcs_pkg::SLCS_OS_LINK:     neg_sel = slcs_pkg::K30_7_NEG;
         default:                    neg_sel = slcs_pkg::K28_5_NEG;
      endcase
   end
   assign tx_next = (os_sel == slcs_pkg::SLCS_OS_NONE) ? tx_data_code_in
                                                       : pick(neg_sel, rd_tx_reg);
   assign tx_ones = ones(tx_next);
   assign tx_data_ready_out = os_sel == slcs_pkg::SLCS_OS_NONE;
   assign tx_code_out = tx_code_reg;
   assign tx_rd_out = rd_tx_reg;
   wire fc_sent = (os_sel == slcs_pkg::SLCS_OS_FLOW_ON) || (os_sel == slcs_pkg::SLCS_OS_FLOW_OFF);
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         rd_tx_reg    <= slcs_pkg::RD_RESET;
         tx_code_reg  <= slcs_pkg::K28_5_NEG;
         timer_reg    <= 13'h0000;
         link_due_reg <= 1'b0;
         fc_on_reg    <= 1'b0;
      end else begin
         tx_code_reg <= tx_next;
         if (tx_ones != 4'h5) begin
            rd_tx_reg <= tx_ones > 4'h5;
         end
         timer_reg <= timer_hit ? 13'h0000 : timer_reg + 13'h0001;
         if (os_sel == slcs_pkg::SLCS_OS_LINK) begin
            link_due_reg <= 1'b0;
         end
         if (timer_hit) begin
            link_due_reg <= 1'b1;
         end
         if (fc_sent || v2_mode_in) begin
            fc_on_reg <= rx_queue_full_in;
         end
      end
   end
   // ------------------------------------------------------------
   // Receive decoding
   // ------------------------------------------------------------
   logic       rd_rx_reg;
   logic       stop_reg;
   logic       rx_ctrl_reg;
   logic       rx_err_reg;
   logic [7:0] rx_oct_reg;
   logic [3:0] rx_set_reg;
   logic [7:0] k_oct;
   logic       k_hit;
   wire  [9:0] rx_neg = rd_rx_reg ? ~rx_code_in : rx_code_in;
   wire  [3:0] rx_ones = ones(rx_code_in);
   always_comb begin
      k_hit = 1'b1;
      case (rx_neg)
         slcs_pkg::K28_0_NEG: k_oct = slcs_pkg::K28_0_OCT;
         slcs_pkg::K28_1_NEG: k_oct = slcs_pkg::K28_1_OCT;
         slcs_pkg::K28_2_NEG: k_oct = slcs_pkg::K28_2_OCT;
         slcs_pkg::K28_3_NEG: k_oct = slcs_pkg::K28_3_OCT;
         slcs_pkg::K28_4_NEG: k_oct = slcs_pkg::K28_4_OCT;
         slcs_pkg::K28_5_NEG: k_oct = slcs_pkg::K28_5_OCT;
         slcs_pkg::K28_6_NEG: k_oct = slcs_pkg::K28_6_OCT;
         slcs_pkg::K28_7_NEG: k_oct = slcs_pkg::K28_7_OCT;
         slcs_pkg::K23_7_NEG: k_oct = slcs_pkg::K23_7_OCT;
         slcs_pkg::K27_7_NEG: k_oct = slcs_pkg::K27_7_OCT;
         slcs_pkg::K29_7_NEG: k_oct = slcs_pkg::K29_7_OCT;
         slcs_pkg::K30_7_NEG: k_oct = slcs_pkg::K30_7_OCT;
         default: begin
            k_oct = 8'h00;
            k_hit = 1'b0;
         end
      endcase
   end
   slcs_pkg::slcs_os_e rx_set;
   always_comb begin
      case (k_oct)
         slcs_pkg::K28_5_OCT: rx_set = slcs_pkg::SLCS_OS_IDLE;
         slcs_pkg::K29_7_OCT: rx_set = slcs_pkg::SLCS_OS_EOP;
         slcs_pkg::K23_7_OCT: rx_set = slcs_pkg::SLCS_OS_BYTE_DIS;
         slcs_pkg::K28_0_OCT: rx_set = slcs_pkg::SLCS_OS_FLOW_ON;
         slcs_pkg::K28_2_OCT: rx_set = slcs_pkg::SLCS_OS_FLOW_OFF;
         slcs_pkg::K28_1_OCT: rx_set = slcs_pkg::SLCS_OS_ERROR;
         slcs_pkg::K28_4_OCT: rx_set = slcs_pkg::SLCS_OS_INIT0;
         slcs_pkg::K28_6_OCT: rx_set = slcs_pkg::SLCS_OS_INIT1;
         slcs_pkg::K30_7_OCT: rx_set = slcs_pkg::SLCS_OS_LINK;
         default:             rx_set = slcs_pkg::SLCS_OS_NONE;
      endcase
   end
   wire rx_bad = !(k_hit && rx_set != slcs_pkg::SLCS_OS_NONE && 1'b1) && !k_hit && !rx_is_data_in;
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         rd_rx_reg   <= slcs_pkg::RD_RESET;
         stop_reg    <= 1'b0;
         rx_ctrl_reg <= 1'b0;
         rx_err_reg  <= 1'b0;
         rx_oct_reg  <= 8'h00;
         rx_set_reg  <= 4'(slcs_pkg::SLCS_OS_NONE);
      end else begin
         rx_ctrl_reg <= rx_valid_in && k_hit;
         rx_err_reg  <= rx_valid_in && rx_bad;
         if (rx_valid_in) begin
            rx_oct_reg <= k_oct;
            rx_set_reg <= 4'(k_hit ? rx_set : slcs_pkg::SLCS_OS_NONE);
            if (rx_ones != 4'h5) begin
               rd_rx_reg <= rx_ones > 4'h5;
            end
            if (k_hit && rx_set == slcs_pkg::SLCS_OS_FLOW_ON) begin
               stop_reg <= 1'b1;
            end else if (k_hit && rx_set == slcs_pkg::SLCS_OS_FLOW_OFF) begin
               stop_reg <= 1'b0;
            end
         end
      end
   end
   assign rx_ctrl_out     = rx_ctrl_reg;
   assign rx_octet_out    = rx_oct_reg;
   assign rx_set_out      = rx_set_reg;
   assign rx_error_out    = rx_err_reg;
   assign remote_stop_out = stop_reg;
endmodule
`default_nettype wire

// file: verif/slcs_checker.sv
// Purpose: Port assertions for the control-symbol layer.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Timer link groups may pre-empt lower transmit requests.
`timescale 1ns/1ps
`default_nettype none
module slcs_checker #(
   parameter int LINK_TIMER = slcs_pkg::LINK_TIMER_CYCLES
) (
   // Clock and reset
   input wire logic       clk_sys_in,
   input wire logic       rst_in,
   // Transmit side
   input wire logic [9:0] tx_data_code_in,
   input wire logic       pkt_fault_in,
   input wire logic       link_init_in,
   input wire logic       tx_data_ready_out,
   input wire logic [9:0] tx_code_out,
   input wire logic       tx_rd_out,
   // Receive side
   input wire logic       rx_valid_in,
   input wire logic [9:0] rx_code_in,
   input wire logic       rx_is_data_in,
   input wire logic       rx_ctrl_out,
   input wire logic [3:0] rx_set_out,
   input wire logic       rx_error_out,
   input wire logic       remote_stop_out
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (rst_in);
   sequence s_sent(logic [9:0] n);
      tx_code_out == ($past(tx_rd_out) ? ~n : n);
   endsequence
   sequence s_rxk(logic [9:0] n);
      rx_valid_in && !rx_is_data_in && (rx_code_in == n || rx_code_in == ~n);
   endsequence
   a_error_wins: assert property (pkt_fault_in |=> s_sent(10'h0F9))
      else $error("error group not sent");
   a_link_init: assert property (link_init_in && !pkt_fault_in |=> s_sent(10'h1E8))
      else $error("link group not sent");
   a_data_pass: assert property (tx_data_ready_out |=> tx_code_out == $past(tx_data_code_in))
      else $error("data group not passed");
   a_rd_track: assert property (!$past(rst_in) |-> tx_rd_out ==
      ($countones(tx_code_out) == 5 ? $past(tx_rd_out) : $countones(tx_code_out) > 5))
      else $error("disparity wrong");
   a_idle_decode: assert property (s_rxk(10'h0FA) |=> rx_ctrl_out && rx_set_out == 4'h0)
      else $error("idle not decoded");
   a_bad_group: assert property (s_rxk(10'h000) |=> rx_error_out && !rx_ctrl_out)
      else $error("illegal group not flagged");
   a_stop_set: assert property (s_rxk(10'h0F4) |=> remote_stop_out)
      else $error("stop not set");
   a_stop_hold: assert property (!rx_valid_in |=> $stable(remote_stop_out))
      else $error("stop changed without group");
endmodule
bind slcs_link slcs_checker #(.LINK_TIMER(LINK_TIMER)) chk_i (.*);
`default_nettype wire

// file: verif/slcs_remote.sv
// Purpose: Far-end link model that sends received groups.
// Assumes: Specials arrive in negative form; kind 0 special, 1 data, 2 illegal.
// Notes:   A released line toggles each cycle between the inverse of the last group and the group, never a held value.
`timescale 1ns/1ps
`default_nettype none
module slcs_remote (
   // Clock and request
   input  wire logic       clk_sys_in,
   input  wire logic       send_in,
   input  wire logic [1:0] kind_in,
   input  wire logic [9:0] code_in,
   // Link side
   output logic            rx_valid_out,
   output logic [9:0]      rx_code_out,
   output logic            rx_is_data_out
);
   logic       rd_reg   = 1'b0;
   logic [9:0] code_reg = 10'h000;
   logic [9:0] w;
   assign w = (kind_in == 2'h0 && rd_reg) ? ~code_in
                                          : code_in;
   assign rx_code_out = code_reg;
   always @(posedge clk_sys_in) begin
      rx_valid_out <= send_in;
      rx_is_data_out <= send_in && kind_in == 2'h1;
      code_reg <= send_in ? w : ~code_reg;
      if (send_in && $countones(w) != 5) rd_reg <= $countones(w) > 5;
   end
endmodule
`default_nettype wire

// file: verif/serial_link_control_symbols_test.sv
// Purpose: Self-checking bench for the control-symbol layer.
// Assumes: Link timer shortened to 16 cycles.
// Notes:   Unrequested link groups count as timer expiries, since their phase is unknown.
`timescale 1ns/1ps
`default_nettype none
module serial_link_control_symbols_test;
   localparam logic [9:0] KN [12] = '{10'h0FA, 10'h2E8, 10'h3A8, 10'h0F4, 10'h0F5, 10'h0F9,
      10'h0F2, 10'h0F6, 10'h1E8, 10'h0F3, 10'h0F8, 10'h368};
   localparam logic [7:0] KO [12] = '{8'hBC, 8'hFD, 8'hF7, 8'h1C, 8'h5C, 8'h3C, 8'h9C, 8'hDC,
      8'hFE, 8'h7C, 8'hFC, 8'hFB};
   logic        clk_sys_in = 1'b0, rst_in = 1'b1, v2 = 1'b0, dv = 1'b0, qf = 1'b0, snd = 1'b0;
   logic        rde = 1'b0, qp = 1'b0, stp = 1'b0, qw, uns, rk, rdy, rd, rv, rdat, ctl, err, stop;
   logic        qn;
   logic [5:0]  rq = 6'h00;
   logic [9:0]  dcode = 10'h000, pcode = 10'h000, ex, ul, code, rcode;
   logic [1:0]  kind = 2'h0;
   logic [7:0]  oct;
   logic [3:0]  set;
   logic [31:0] r;
   int          seed = 32'haaec1900, ix, j, lcnt = 0, err_total = 0, check_count = 0;
   slcs_link #(.LINK_TIMER(16)) uut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .v2_mode_in(v2),
      .tx_data_valid_in(dv), .tx_data_code_in(dcode), .tx_eop_in(rq[1]), .tx_byte_dis_in(rq[0]),
      .rx_queue_full_in(qf), .pkt_fault_in(rq[5]), .link_init_in(rq[4]), .init0_in(rq[3]),
      .init1_in(rq[2]), .tx_data_ready_out(rdy), .tx_code_out(code), .tx_rd_out(rd),
      .rx_valid_in(rv), .rx_code_in(rcode), .rx_is_data_in(rdat), .rx_ctrl_out(ctl),
      .rx_octet_out(oct), .rx_set_out(set), .rx_error_out(err), .remote_stop_out(stop));
   slcs_remote peer (.clk_sys_in(clk_sys_in), .send_in(snd), .kind_in(kind), .code_in(pcode),
      .rx_valid_out(rv), .rx_code_out(rcode), .rx_is_data_out(rdat));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic rx(input logic [1:0] k, input logic [9:0] c);
      @(posedge clk_sys_in);
      snd <= 1'b1;
      kind <= k;
      pcode <= c;
      @(posedge clk_sys_in);
      snd <= 1'b0;
      @(posedge clk_sys_in);
      #1;
   endtask
   initial forever #2.5 clk_sys_in = ~clk_sys_in;
   always @(posedge clk_sys_in) begin
      ix = rq[5] ? 5 : rq[4] ? 8 : rq[3] ? 6 : rq[2] ? 7 : (qf != qp && !v2) ? (qf ? 3 : 4) :
         rq[1] ? 1 : rq[0] ? 2 : dv ? 12 : 0;
      ex = ix == 12 ? dcode : (rde ? ~KN[ix] : KN[ix]);
      ul = rde ? ~KN[8] : KN[8];
      qn = (ix == 3 || ix == 4 || v2) ? qf : qp;
      qw = rst_in;
      rk = rdy;
      #1;
      if (qw) rde = 1'b0;
      else begin
         uns = ix != 5 && ix != 8 && code === ul;
         if (uns) ex = ul;
         lcnt += uns;
         // A flow code pre-empted by a timer link group is still owed next cycle.
         if (!(uns && (ix == 3 || ix == 4))) qp = qn;
         chk(code, ex, "tx code");
         chk(rk, ix == 12 && !uns, "tx ready");
         rde = $countones(ex) == 5 ? rde : $countones(ex) > 5;
         chk(rd, rde, "tx disparity");
      end
   end
   initial begin
      repeat (20) @(posedge clk_sys_in);
      #1;
      chk({code, rd, set}, {10'h0FA, 1'b0, 4'h9}, "reset outputs");
      @(posedge clk_sys_in);
      rst_in <= 1'b0;
      repeat (300) begin
         @(posedge clk_sys_in);
         r = $random(seed);
         rq <= {r[3:0] == 0, r[7:4] == 0, r[10:8] == 0,
                r[13:11] == 0, r[15:14] == 0, r[17:16] == 0};
         dv <= r[18];
         // Data never takes a link form, so an unrequested link group on the line is always the timer's.
         dcode <= {r[31:24], 2'h1};
      end
      for (int m = 0; m < 2; m++) begin
         @(posedge clk_sys_in);
         rq <= 6'h00;
         dv <= 1'b0;
         v2 <= m[0];
         j = lcnt;
         for (int w = 0; w < 40 && j == lcnt; w++) @(posedge clk_sys_in);
         qf <= 1'b1;
         repeat (4) @(posedge clk_sys_in);
         qf <= 1'b0;
         repeat (4) @(posedge clk_sys_in);
      end
      j = lcnt;
      repeat (200) @(posedge clk_sys_in);
      chk(lcnt - j >= 11 && lcnt - j <= 13, 1'b1, "timer link count");
      for (int n = 0; n < 80; n++) begin
         r = $random(seed);
         j = n < 14 ? n : r[7:0] % 14;
         rx(j < 12 ? 2'h0 : j == 12 ? 2'h1 : 2'h2,
            j < 12 ? KN[j] : j == 12 ? {r[9:8], 8'hAA} : 10'h000);
         if (j == 3 || j == 4) stp = j == 3;
         chk({ctl, err}, {j < 12, j == 13}, "rx flags");
         chk(oct, j < 12 ? KO[j] : 8'h00, "rx octet");
         chk(set, j < 9 ? j : 9, "rx set");
         chk(stop, stp, "remote stop");
      end
      tally_and_finish;
   end
   initial begin
      #10000;
      err_total++;
      tally_and_finish;
   end
endmodule
`default_nettype wire
